// [ams_sequencer.sv]
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module ams_sequencer #(
  parameter int unsigned LONG_PRESS_CYC = ams_pkg::LONG_PRESS_CYC,
  parameter int unsigned IDENT_CYC = ams_pkg::IDENT_CYC,
  parameter int unsigned WG_TIMEOUT_CYC = ams_pkg::WG_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Keypad and panel inputs
  input wire logic [9:0] key_in,
  input wire logic [8:0] lim_in,
  input wire logic wg_sense_h,
  input wire logic wg_sense_v,
  input wire logic [2:0] stall_det,
  input wire logic [2:0] run_det,
  // Position sensor voltages in millivolts
  input wire logic [12:0] meas_az,
  input wire logic [12:0] meas_el,
  input wire logic [12:0] meas_pol,
  // Motor and waveguide drive
  output logic [2:0] drv_pos,
  output logic [2:0] drv_neg,
  output logic drv_fast,
  output logic wg_drive_h,
  output logic wg_drive_v,
  // Display fields
  output logic [3:0] disp_screen,
  output logic disp_confirm,
  output logic disp_fast,
  output logic [7:0] disp_wg_char,
  output logic [2:0][13:0] disp_pos,
  output logic [8:0] disp_limits,
  output logic [2:0][1:0] disp_fault,
  output logic [12:0] disp_ref_stored,
  output logic [12:0] disp_ref_live
);

  typedef struct packed {
    logic [16:0] sync1_q;
    logic [16:0] sync2_q;
    ams_pkg::ams_mode_t mode_q;
    logic [31:0] cnt_q;
    logic fast_q;
    logic confirm_q;
    logic [12:0] pend_q;
    logic [1:0] step_q;
    logic step_run_q;
    logic auto_dir_q;
    logic [2:0][1:0] fault_q;
    logic wg_move_q;
    logic wg_to_h_q;
    logic [31:0] wg_cnt_q;
    logic [1:0] wg_drv_q;
    logic [2:0] ctrl_q;
    logic [5:0][13:0] tgt_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [2:0] drv_pos_q;
    logic [2:0] drv_neg_q;
    logic [7:0] wg_char_q;
    logic [2:0][13:0] pos_q;
    logic [8:0] lim_q;
    logic [12:0] ref_stored_q;
    logic [12:0] ref_live_q;
  } ams_seq_t;

  ams_seq_t r;
  ams_seq_t n;

  logic [9:0] key_held;
  logic [9:0] key_press;
  logic mode_short;
  logic mode_long;
  logic [2:0][12:0] ref_rd;
  logic [2:0][12:0] meas;
  logic signed [13:0] pos [3];
  logic [2:0] req_pos;
  logic [2:0] req_neg;
  logic ref_we;
  logic [1:0] ref_axis;
  logic [1:0] cur_axis;
  logic [3:0] tgt_idx;
  logic reached;

  // Axis moved by a given step of deploy or stow
  function automatic logic [1:0] seq_axis(input logic stow,
                                          input logic [1:0] step);
    if (stow) begin
      if (step == 2'h0) begin
        return ams_pkg::AX_AZ;
      end else if (step == 2'h1) begin
        return ams_pkg::AX_POL;
      end else begin
        return ams_pkg::AX_EL;
      end
    end else begin
      if (step == 2'h0) begin
        return ams_pkg::AX_EL;
      end else if (step == 2'h1) begin
        return ams_pkg::AX_AZ;
      end else begin
        return ams_pkg::AX_POL;
      end
    end
  endfunction : seq_axis

  // True for any mapped register byte address
  function automatic logic addr_mapped(input logic [7:0] a);
    if (a[1:0] != 2'h0) begin
      return 1'b0;
    end else if (a <= ams_pkg::A_TGT5) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : addr_mapped

  // Key conditioning and long-press timing
  ams_keys #(
    .LONG_CYC(LONG_PRESS_CYC)
  ) u_keys (
    .pclk(pclk),
    .presetn(presetn),
    .key_in(key_in),
    .key_held(key_held),
    .key_press(key_press),
    .mode_short(mode_short),
    .mode_long(mode_long)
  );

  // Stored reference voltages
  ams_refmem u_refmem (
    .pclk(pclk),
    .presetn(presetn),
    .we(ref_we),
    .waddr(ref_axis),
    .wdata(r.pend_q),
    .rdata(ref_rd)
  );

  // Positions relative to stored references
  assign meas = {meas_pol, meas_el, meas_az};
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pos[i] = $signed({1'b0, meas[i]}) - $signed({1'b0, ref_rd[i]});
    end
  end

  // Reference screen selection and commit strobe
  assign ref_axis = 2'(r.mode_q - ams_pkg::M_AZ_REF);
  assign ref_we = (r.mode_q >= ams_pkg::M_AZ_REF) && r.confirm_q &&
                  key_press[ams_pkg::K_DN];
  assign cur_axis = seq_axis(r.mode_q == ams_pkg::M_STOW, r.step_q);
  assign tgt_idx = (r.mode_q == ams_pkg::M_STOW) ? 4'(cur_axis) + 4'h3
                                                 : 4'(cur_axis);
  assign reached = r.auto_dir_q ?
                   (pos[cur_axis] >= $signed(r.tgt_q[tgt_idx])) :
                   (pos[cur_axis] <= $signed(r.tgt_q[tgt_idx]));

  // Drive requests before interlocks
  always_comb begin
    req_pos = 3'h0;
    req_neg = 3'h0;
    if (r.mode_q == ams_pkg::M_MANUAL) begin
      req_neg[ams_pkg::AX_AZ] = key_held[ams_pkg::K_AZ_CCW];
      req_pos[ams_pkg::AX_AZ] = key_held[ams_pkg::K_AZ_CW];
      req_neg[ams_pkg::AX_EL] = key_held[ams_pkg::K_EL_DN];
      req_pos[ams_pkg::AX_EL] = key_held[ams_pkg::K_EL_UP];
      req_neg[ams_pkg::AX_POL] = key_held[ams_pkg::K_POL_CCW];
      req_pos[ams_pkg::AX_POL] = key_held[ams_pkg::K_POL_CW];
      // Both keys of one axis held: no motion
      req_pos = req_pos & ~req_neg;
      req_neg = req_neg & ~{key_held[ams_pkg::K_POL_CW],
                            key_held[ams_pkg::K_EL_UP],
                            key_held[ams_pkg::K_AZ_CW]};
    end else if ((r.mode_q == ams_pkg::M_DEPLOY ||
                  r.mode_q == ams_pkg::M_STOW) && r.step_run_q &&
                 !reached) begin
      req_pos[cur_axis] = r.auto_dir_q;
      req_neg[cur_axis] = !r.auto_dir_q;
    end
  end

  // Main sequencing, interlocks, display and register file
  always_comb begin
    n = r;
    n.sync1_q = {stall_det, run_det, wg_sense_v, wg_sense_h, lim_in};
    n.sync2_q = r.sync1_q;

    // Faults: detection wins over a clear in the same cycle
    for (int i = 0; i < 3; i++) begin
      if (r.mode_q == ams_pkg::M_DRV_RESET && key_press[ams_pkg::K_FS]) begin
        n.fault_q[i] = ams_pkg::FLT_OK;
      end
      if (r.sync2_q[14 + i]) begin
        n.fault_q[i] = ams_pkg::FLT_STALL;
      end else if (r.sync2_q[11 + i]) begin
        n.fault_q[i] = ams_pkg::FLT_RUN;
      end
    end

    // Interlocks on every axis
    for (int i = 0; i < 3; i++) begin
      n.drv_pos_q[i] = req_pos[i] && !r.sync2_q[3 * i + ams_pkg::LIM_POS] &&
                       r.fault_q[i] == ams_pkg::FLT_OK;
      n.drv_neg_q[i] = req_neg[i] && !r.sync2_q[3 * i + ams_pkg::LIM_NEG] &&
                       r.fault_q[i] == ams_pkg::FLT_OK;
    end
    if (r.sync2_q[3 * ams_pkg::AX_EL + ams_pkg::LIM_NEG]) begin
      n.drv_pos_q[ams_pkg::AX_AZ] = 1'b0;
      n.drv_neg_q[ams_pkg::AX_AZ] = 1'b0;
    end

    // Screen sequencing
    case (r.mode_q)
      ams_pkg::M_IDENT: begin
        n.cnt_q = r.cnt_q + 32'h1;
        if (r.cnt_q == 32'(IDENT_CYC - 1)) begin
          n.mode_q = ams_pkg::M_MANUAL;
          n.cnt_q = 32'h0;
        end
      end
      ams_pkg::M_MANUAL: begin
        if (key_press[ams_pkg::K_FS]) begin
          n.fast_q = !r.fast_q;
        end
        if (mode_short) begin
          n.mode_q = ams_pkg::M_AUTO;
        end
      end
      ams_pkg::M_AUTO: begin
        if (key_press[ams_pkg::K_UP]) begin
          n.mode_q = ams_pkg::M_DEPLOY;
        end else if (key_press[ams_pkg::K_DN]) begin
          n.mode_q = ams_pkg::M_STOW;
        end else if (key_press[ams_pkg::K_FS] &&
                     r.ctrl_q[ams_pkg::CTRL_WG_FIT]) begin
          n.mode_q = ams_pkg::M_WAVEGUIDE;
        end else if (mode_short) begin
          n.mode_q = ams_pkg::M_MANUAL;
        end
        n.step_q = 2'h0;
        n.step_run_q = 1'b0;
      end
      ams_pkg::M_DEPLOY, ams_pkg::M_STOW: begin
        if (key_press != 10'h0) begin
          n.mode_q = ams_pkg::M_AUTO;
          n.step_run_q = 1'b0;
        end else if (cur_axis == ams_pkg::AX_POL &&
                     !r.ctrl_q[ams_pkg::CTRL_POL_EN]) begin
          n.step_q = r.step_q + 2'h1;
          if (r.step_q == 2'h2) begin
            n.mode_q = ams_pkg::M_MANUAL;
          end
        end else if (!r.step_run_q) begin
          n.step_run_q = 1'b1;
          n.auto_dir_q = pos[cur_axis] < $signed(r.tgt_q[tgt_idx]);
        end else if (reached) begin
          n.step_run_q = 1'b0;
          n.step_q = r.step_q + 2'h1;
          if (r.step_q == 2'h2) begin
            n.mode_q = ams_pkg::M_MANUAL;
          end
        end
      end
      ams_pkg::M_WAVEGUIDE: begin
        if (mode_short) begin
          n.mode_q = ams_pkg::M_MANUAL;
        end
      end
      ams_pkg::M_DRV_RESET: begin
        if (mode_short) begin
          n.mode_q = ams_pkg::M_AZ_REF;
        end
      end
      ams_pkg::M_AZ_REF, ams_pkg::M_EL_REF, ams_pkg::M_POL_REF: begin
        if (key_press[ams_pkg::K_UP] && !r.confirm_q) begin
          n.confirm_q = 1'b1;
          n.pend_q = meas[ref_axis];
        end else if (ref_we) begin
          n.confirm_q = 1'b0;
        end
        if (mode_short) begin
          n.confirm_q = 1'b0;
          n.mode_q = (r.mode_q == ams_pkg::M_POL_REF) ?
                     ams_pkg::M_DRV_RESET :
                     ams_pkg::ams_mode_t'(r.mode_q + 4'h1);
        end
      end
      default: begin
        n.mode_q = ams_pkg::M_MANUAL;
      end
    endcase

    // Long Mode hold swaps between operating and programming groups
    if (mode_long && r.mode_q != ams_pkg::M_IDENT) begin
      n.confirm_q = 1'b0;
      n.step_run_q = 1'b0;
      n.mode_q = (r.mode_q >= ams_pkg::M_DRV_RESET) ? ams_pkg::M_MANUAL
                                                    : ams_pkg::M_DRV_RESET;
    end

    // Waveguide switch travel with timeout
    if (r.wg_move_q) begin
      n.wg_cnt_q = r.wg_cnt_q + 32'h1;
      if ((r.wg_to_h_q && r.sync2_q[9]) || (!r.wg_to_h_q && r.sync2_q[10])) begin
        n.wg_move_q = 1'b0;
      end else if (r.wg_cnt_q == 32'(WG_TIMEOUT_CYC - 1)) begin
        n.wg_move_q = 1'b0;
      end
    end else if (r.mode_q == ams_pkg::M_WAVEGUIDE &&
                 key_press[ams_pkg::K_FS]) begin
      n.wg_move_q = 1'b1;
      n.wg_cnt_q = 32'h0;
      n.wg_to_h_q = !(r.sync2_q[9] && !r.sync2_q[10]);
    end
    // Drive lines get their own flops so the pins never glitch
    n.wg_drv_q[0] = n.wg_move_q & n.wg_to_h_q;
    n.wg_drv_q[1] = n.wg_move_q & ~n.wg_to_h_q;

    // Waveguide character
    if (!r.ctrl_q[ams_pkg::CTRL_WG_FIT]) begin
      n.wg_char_q = ams_pkg::CH_SPACE;
    end else if (r.wg_move_q) begin
      n.wg_char_q = r.wg_to_h_q ? ams_pkg::CH_PLUS : ams_pkg::CH_MINUS;
    end else if (r.sync2_q[9] && r.sync2_q[10]) begin
      n.wg_char_q = ams_pkg::CH_STAR;
    end else if (r.sync2_q[9]) begin
      n.wg_char_q = ams_pkg::CH_H;
    end else if (r.sync2_q[10]) begin
      n.wg_char_q = ams_pkg::CH_V;
    end else begin
      n.wg_char_q = ams_pkg::CH_Q;
    end

    // Live positions, limits and reference fields
    for (int i = 0; i < 3; i++) begin
      n.pos_q[i] = pos[i];
    end
    n.lim_q = r.sync2_q[8:0];
    if (!r.ctrl_q[ams_pkg::CTRL_POL_STW]) begin
      n.lim_q[3 * ams_pkg::AX_POL + ams_pkg::LIM_STOW] = 1'b0;
    end
    n.ref_stored_q = (r.mode_q >= ams_pkg::M_AZ_REF) ? ref_rd[ref_axis]
                                                     : 13'h0;
    n.ref_live_q = (r.mode_q >= ams_pkg::M_AZ_REF) ? meas[ref_axis] : 13'h0;

    // APB: data prepared in setup, completed in the access cycle
    if (psel && !penable && !r.pready_q) begin
      n.pready_q = 1'b1;
      n.pslverr_q = !addr_mapped(paddr);
      n.prdata_q = 32'h0;
      if (paddr == ams_pkg::A_CTRL) begin
        n.prdata_q = {29'h0, r.ctrl_q};
      end else if (paddr == ams_pkg::A_STATUS) begin
        n.prdata_q[ams_pkg::ST_MODE +: 4] = r.mode_q;
        n.prdata_q[ams_pkg::ST_FAST] = r.fast_q;
        n.prdata_q[ams_pkg::ST_CONFIRM] = r.confirm_q;
        n.prdata_q[ams_pkg::ST_FAULT +: 6] = r.fault_q;
        n.prdata_q[ams_pkg::ST_WG_MOVE] = r.wg_move_q;
        n.prdata_q[ams_pkg::ST_STEP +: 2] = r.step_q;
      end else if (paddr >= ams_pkg::A_REF0 && paddr <= ams_pkg::A_REF2) begin
        n.prdata_q = {19'h0, ref_rd[2'(paddr[7:2] - 6'h2)]};
      end else if (paddr >= ams_pkg::A_TGT0 && paddr <= ams_pkg::A_TGT5) begin
        n.prdata_q = {{18{r.tgt_q[3'(paddr[7:2] - 6'h5)][13]}},
                      r.tgt_q[3'(paddr[7:2] - 6'h5)]};
      end
    end else if (psel && penable && r.pready_q) begin
      n.pready_q = 1'b0;
      n.pslverr_q = 1'b0;
      if (pwrite && !r.pslverr_q) begin
        if (paddr == ams_pkg::A_CTRL) begin
          n.ctrl_q = pwdata[2:0];
        end else if (paddr >= ams_pkg::A_TGT0 && paddr <= ams_pkg::A_TGT5) begin
          n.tgt_q[3'(paddr[7:2] - 6'h5)] = pwdata[13:0];
        end
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.ctrl_q <= ams_pkg::CTRL_RST;
      r.wg_char_q <= ams_pkg::CH_SPACE;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign prdata = r.prdata_q;
  assign pready = r.pready_q;
  assign pslverr = r.pslverr_q;
  assign drv_pos = r.drv_pos_q;
  assign drv_neg = r.drv_neg_q;
  assign drv_fast = r.fast_q;
  assign wg_drive_h = r.wg_drv_q[0];
  assign wg_drive_v = r.wg_drv_q[1];
  assign disp_screen = r.mode_q;
  assign disp_confirm = r.confirm_q;
  assign disp_fast = r.fast_q;
  assign disp_wg_char = r.wg_char_q;
  assign disp_pos = r.pos_q;
  assign disp_limits = r.lim_q;
  assign disp_fault = r.fault_q;
  assign disp_ref_stored = r.ref_stored_q;
  assign disp_ref_live = r.ref_live_q;

endmodule : ams_sequencer

`default_nettype wire

// [ams_pkg.sv]
package ams_pkg;

  // Clock rate and timed behaviour
  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned LONG_PRESS_MS = 3000;
  localparam int unsigned IDENT_MS = 5000;
  localparam int unsigned WG_TIMEOUT_MS = 5000;
  localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * CLK_KHZ;
  localparam int unsigned IDENT_CYC = IDENT_MS * CLK_KHZ;
  localparam int unsigned WG_TIMEOUT_CYC = WG_TIMEOUT_MS * CLK_KHZ;

  // Key vector positions
  localparam int NKEYS = 10;
  localparam int K_MODE = 0;
  localparam int K_FS = 1;
  localparam int K_UP = 2;
  localparam int K_DN = 3;
  localparam int K_AZ_CCW = 4;
  localparam int K_AZ_CW = 5;
  localparam int K_EL_DN = 6;
  localparam int K_EL_UP = 7;
  localparam int K_POL_CCW = 8;
  localparam int K_POL_CW = 9;

  // Axis numbers and limit positions (three bits per axis)
  localparam logic [1:0] AX_AZ = 2'h0;
  localparam logic [1:0] AX_EL = 2'h1;
  localparam logic [1:0] AX_POL = 2'h2;
  localparam int LIM_STOW = 0;
  localparam int LIM_NEG = 1;
  localparam int LIM_POS = 2;

  // Voltage and position words
  localparam int VOLT_W = 13;
  localparam int POS_W = 14;
  localparam logic [12:0] REF_DEFAULT = 13'h09c4;

  // Axis fault codes
  localparam logic [1:0] FLT_OK = 2'h0;
  localparam logic [1:0] FLT_STALL = 2'h1;
  localparam logic [1:0] FLT_RUN = 2'h2;

  // Waveguide display characters
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_V = 8'h56;
  localparam logic [7:0] CH_Q = 8'h3f;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_SPACE = 8'h20;

  // Screens
  typedef enum logic [3:0] {
    M_IDENT = 4'h0,
    M_MANUAL = 4'h1,
    M_AUTO = 4'h2,
    M_DEPLOY = 4'h3,
    M_STOW = 4'h4,
    M_WAVEGUIDE = 4'h5,
    M_DRV_RESET = 4'h6,
    M_AZ_REF = 4'h7,
    M_EL_REF = 4'h8,
    M_POL_REF = 4'h9
  } ams_mode_t;

  // Register map (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_REF0 = 8'h08;
  localparam logic [7:0] A_REF2 = 8'h10;
  localparam logic [7:0] A_TGT0 = 8'h14;
  localparam logic [7:0] A_TGT5 = 8'h28;
  localparam int CTRL_POL_EN = 0;
  localparam int CTRL_WG_FIT = 1;
  localparam int CTRL_POL_STW = 2;
  localparam logic [2:0] CTRL_RST = 3'h1;
  localparam int ST_MODE = 0;
  localparam int ST_FAST = 4;
  localparam int ST_CONFIRM = 5;
  localparam int ST_FAULT = 6;
  localparam int ST_WG_MOVE = 12;
  localparam int ST_STEP = 13;

endpackage : ams_pkg

// [ams_keys.sv]
`timescale 1ns/10ps
`default_nettype none

// Key synchroniser with press edges and short/long Mode classification
module ams_keys #(
  parameter int unsigned LONG_CYC = ams_pkg::LONG_PRESS_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw keys
  input wire logic [9:0] key_in,
  // Conditioned keys
  output logic [9:0] key_held,
  output logic [9:0] key_press,
  output logic mode_short,
  output logic mode_long
);

  typedef struct packed {
    logic [9:0] s1_q;
    logic [9:0] s2_q;
    logic [9:0] prev_q;
    logic [9:0] press_q;
    logic [31:0] cnt_q;
    logic long_done_q;
    logic short_q;
    logic long_q;
  } ams_keys_t;

  ams_keys_t r;
  ams_keys_t n;

  // Edge detection and hold timing on synchronised keys
  always_comb begin
    n = r;
    n.s1_q = key_in;
    n.s2_q = r.s1_q;
    n.prev_q = r.s2_q;
    n.press_q = r.s2_q & ~r.prev_q;
    n.short_q = 1'b0;
    n.long_q = 1'b0;
    if (r.s2_q[ams_pkg::K_MODE]) begin
      if (!r.long_done_q) begin
        n.cnt_q = r.cnt_q + 32'h1;
        if (r.cnt_q == 32'(LONG_CYC - 1)) begin
          n.long_q = 1'b1;
          n.long_done_q = 1'b1;
        end
      end
    end else begin
      // Release: short press only if the hold never qualified as long
      if (r.prev_q[ams_pkg::K_MODE] && !r.long_done_q) begin
        n.short_q = 1'b1;
      end
      n.cnt_q = 32'h0;
      n.long_done_q = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign key_held = r.s2_q;
  assign key_press = r.press_q;
  assign mode_short = r.short_q;
  assign mode_long = r.long_q;

endmodule : ams_keys

`default_nettype wire

// [ams_refmem.sv]
`timescale 1ns/10ps
`default_nettype none

// Stored reference voltages, one word per axis, registered read data
module ams_refmem (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [12:0] wdata,
  // Read data
  output logic [2:0][12:0] rdata
);

  typedef struct packed {
    logic [2:0][12:0] ref_q;
  } ams_refmem_t;

  ams_refmem_t r;
  ams_refmem_t n;

  // Write one word, others hold
  always_comb begin
    n = r;
    if (we && waddr <= ams_pkg::AX_POL) begin
      n.ref_q[waddr] = wdata;
    end
  end

  // Every word resets to the centred value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= {3{ams_pkg::REF_DEFAULT}};
    end else begin
      r <= n;
    end
  end

  assign rdata = r.ref_q;

endmodule : ams_refmem

`default_nettype wire

// [ams_props.sv]
`timescale 1ns/10ps
`default_nettype none
// Port checks of the mode sequencer
module ams_props (
  // Clock, reset, bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Panel and drives
  input wire logic [9:0] key_in,
  input wire logic [2:0] drv_pos,
  input wire logic [2:0] drv_neg,
  input wire logic wg_drive_h,
  input wire logic wg_drive_v,
  input wire logic [3:0] disp_screen
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer and refusal
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_err; pready && paddr > 8'h28 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slave error");
  // Screens and drives
  property p_idle; disp_screen == 4'h0 |-> !(drv_pos | drv_neg);
  endproperty
  a_idle: assert property (p_idle) else $error("drive on ident");
  property p_idx; disp_screen == 4'h0 |=> disp_screen inside {0, 1};
  endproperty
  a_idx: assert property (p_idx) else $error("bad exit");
  property p_both; (drv_pos & drv_neg) == 3'h0; endproperty
  a_both: assert property (p_both) else $error("both ways");
  property p_mdrv; |(drv_pos | drv_neg) |-> disp_screen inside {1, 3, 4}
    || $past(disp_screen) inside {1, 3, 4}; endproperty
  a_mdrv: assert property (p_mdrv) else $error("drive in mode");
  property p_rel; !key_in[5] [*6] ##0 disp_screen == 4'h1 |-> !drv_pos[0];
  endproperty
  a_rel: assert property (p_rel) else $error("jog held on");
  property p_wg; !(wg_drive_h && wg_drive_v); endproperty
  a_wg: assert property (p_wg) else $error("waveguide both");
  property p_stw; disp_screen == 4'h4 |=> disp_screen inside {1, 2, 4, 6};
  endproperty
  a_stw: assert property (p_stw) else $error("stow exit");
  // Main scenarios seen
  c_dep: cover property (disp_screen == 4'h3);
  c_stw: cover property (disp_screen == 4'h4);
  c_ref: cover property (disp_screen == 4'h7);
endmodule : ams_props
bind ams_sequencer ams_props u_props (.*);
`default_nettype wire

// [ams_plant.sv]
`timescale 1ns/10ps
`default_nettype none
// Axes: sensor follows the drive by 1 mV a cycle
module ams_plant (
  // Clock and drives
  input wire logic pclk,
  input wire logic [2:0] drv_pos,
  input wire logic [2:0] drv_neg,
  // Sensors and limits
  output logic [12:0] meas_az,
  output logic [12:0] meas_el,
  output logic [12:0] meas_pol,
  output logic [8:0] lim_in
);
  // Elevation starts inside its down region
  initial begin
    meas_az = 13'h09c4;
    meas_el = 13'h09ba;
    meas_pol = 13'h09c4;
  end
  // Integrate the drives
  always @(posedge pclk) begin
    meas_az <= meas_az + 13'(drv_pos[0]) - 13'(drv_neg[0]);
    meas_el <= meas_el + 13'(drv_pos[1]) - 13'(drv_neg[1]);
    meas_pol <= meas_pol + 13'(drv_pos[2]) - 13'(drv_neg[2]);
  end
  // Only the elevation down switch is fitted
  assign lim_in = {4'h0, meas_el < 13'h09c4, 4'h0};
endmodule : ams_plant
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
  $display("Error %s exp %0h got %0h", n, e, s); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re, conf, fast;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] key_in;
  logic [8:0] lim_in;
  logic [12:0] m_az, m_el, m_pol;
  logic [2:0] drv_pos, drv_neg, stall, run;
  logic wg_h, wg_v, wdv;
  logic [7:0] wch;
  logic [5:0] flt;
  logic [3:0] scr;
  int n_fail, checked;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} ams_row_t;
  ams_row_t rows[6] = '{'{8'h00, 32'h1, 1'b0}, '{8'h04, 32'h0, 1'b0},
    '{8'h08, 32'h9c4, 1'b0}, '{8'h0c, 32'h9c4, 1'b0},
    '{8'h10, 32'h9c4, 1'b0}, '{8'h2c, 32'h0, 1'b1}};
  ams_sequencer #(.LONG_PRESS_CYC(20), .IDENT_CYC(30), .WG_TIMEOUT_CYC(40))
    u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .key_in, .lim_in, .wg_sense_h(wg_h),
    .wg_sense_v(wg_v), .stall_det(stall), .run_det(run), .meas_az(m_az),
    .meas_el(m_el), .meas_pol(m_pol), .drv_pos, .drv_neg, .drv_fast(),
    .wg_drive_h(), .wg_drive_v(wdv), .disp_screen(scr), .disp_confirm(conf),
    .disp_fast(fast), .disp_wg_char(wch), .disp_pos(), .disp_limits(),
    .disp_fault(flt), .disp_ref_stored(), .disp_ref_live());
  ams_plant u_plant (.pclk, .drv_pos, .drv_neg, .meas_az(m_az),
    .meas_el(m_el), .meas_pol(m_pol), .lim_in);
  // Clock
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  // Bus transfer held until ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    re = pslverr;
    {psel, penable} <= 2'b0;
  endtask : apb
  // Press a key for a few cycles
  task key(input int k);
    @(posedge pclk) key_in[k] <= 1;
    repeat (2) @(posedge pclk);
    key_in[k] <= 0;
    repeat (8) @(posedge pclk);
  endtask : key
  task wait_scr(input logic [3:0] s);
    for (int i = 0; i < 400 && scr !== s; i++) @(posedge pclk);
    `CHK("screen", s, scr)
  endtask : wait_scr
  task jog(input int k, input logic e);
    @(posedge pclk) key_in[k] <= 1;
    repeat (24) @(posedge pclk);
    `CHK("jog", e, drv_pos[k-4>>1])
    key_in[k] <= 0;
    repeat (6) @(posedge pclk);
    `CHK("stop", 1'b0, drv_pos[k-4>>1])
  endtask : jog
  task wrap_up;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #20000 n_fail++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, key_in} = 0;
    {wg_h, wg_v, stall, run} = 0;
    repeat (3) @(posedge pclk);
    `CHK("screen", 4'h0, scr)
    presetn <= 1;
    foreach (rows[i]) begin
      apb(0, rows[i].a, 0);
      `CHK("rdata", rows[i].d, rd)
      `CHK("err", rows[i].e, re)
    end
    wait_scr(4'h1);
    jog(5, 1'b0);
    jog(7, 1'b1);
    jog(5, 1'b1);
    key(1);
    `CHK("fast", 1'b1, fast)
    key(0);
    wait_scr(4'h2);
    for (int i = 0; i < 3; i++) apb(1, 8'h14 + 8'(4 * i), 32'h10);
    apb(1, 8'h20, 32'hffffff38);
    key(2);
    wait_scr(4'h1);
    key(0);
    key(3);
    `CHK("stow_az", 1'b1, drv_neg[0])
    key(1);
    wait_scr(4'h2);
    `CHK("halt", 1'b0, drv_neg[0])
    wg_h <= 1;
    apb(1, 8'h00, 32'h3);
    key(1);
    wait_scr(4'h5);
    `CHK("wg_char", 8'h48, wch)
    key(1);
    `CHK("wg_char", 8'h2d, wch)
    `CHK("wg_drv", 1'b1, wdv)
    repeat (40) @(posedge pclk);
    `CHK("wg_tmo", 1'b0, wdv)
    wg_v <= 1;
    key(0);
    `CHK("wg_both", 8'h2a, wch)
    wait_scr(4'h1);
    @(posedge pclk) key_in[0] <= 1;
    wait_scr(4'h6);
    key_in[0] <= 0;
    stall[0] <= 1;
    run[2] <= 1;
    key(1);
    `CHK("fault", 6'h21, flt)
    stall <= 3'h0;
    run <= 3'h0;
    key(1);
    `CHK("fault_clr", 6'h00, flt)
    key(0);
    wait_scr(4'h7);
    key(2);
    `CHK("confirm", 1'b1, conf)
    key(3);
    `CHK("committed", 1'b0, conf)
    apb(0, 8'h08, 0);
    `CHK("ref_az", {19'h0, m_az}, rd)
    key(2);
    key(0);
    wait_scr(4'h8);
    key(2);
    key(0);
    wait_scr(4'h9);
    apb(0, 8'h0c, 0);
    `CHK("ref_el", 32'h9c4, rd)
    presetn <= 0;
    repeat (2) @(posedge pclk);
    `CHK("rst_scr", 4'h0, scr)
    presetn <= 1;
    apb(0, 8'h08, 0);
    `CHK("rst_ref", 32'h9c4, rd)
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
